// file: core/dtc_dram_timing_config.v
// DRAM timing selection with Wishbone register access and a leadoff and burst sequencer.
// Summary of operation
// - Row miss: address setup before row strobe is 1 clock when fast bit set, else 2.
// - Address-to-row-strobe delay is applied independently of the leadoff field.
// - Read burst field picks x444/x333/x222/x322 for EDO, x444/x333 for page mode.
// - Each bank uses the EDO or page mode read column by its recorded type.
// - Fast path with EDO x322: fast leadoff, select output dropped for burst.
// - Fast path with EDO x222: leadoff and the first three burst transfers use fast path; select drops at the fourth.
// - Fast path off with EDO x222: leadoff and burst use the slow path.
// - Write burst field gives x444, x333, x222; code 11 is reserved.
// - Row-to-column strobe delay is 2 clocks when fast bit set, else 3.
// - Leadoff field changes leadoff only for row and page misses, never page hits; precharge follows it on every cycle kind.
// - Leadoff codes give read 11/10/11/10, write 7/6/7/6, precharge 3/3/4/4.
// - Fast row-to-column, speculative, fast path and fast address bits each save a clock.
// - Timing register resets to zero, selecting the slowest delays except the short 3-clock precharge.
// - Fast path bit asserts the select output for EDO reads, one clock less leadoff.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "dtc_consts.vh"

module dtc_dram_timing_config #(
    parameter NUM_ROWS = 5
) (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        dram_start,
    input  wire [2:0]  dram_row,
    input  wire        dram_write,
    input  wire [1:0]  dram_kind,
    output reg         dram_busy,
    output reg         leadoff_phase,
    output reg         xfer_pulse,
    output reg         data_path_select_out,
    output reg  [3:0]  ma_to_ras_clks,
    output reg  [3:0]  ras_to_cas_clks,
    output reg  [3:0]  leadoff_clks,
    output reg  [3:0]  precharge_clks,
    output reg  [2:0]  burst_spacing_clks
);

    // ----------------------------------------------------------------------
    // Cycle kinds and sequencer states
    // ----------------------------------------------------------------------
    localparam [1:0] KIND_PAGE_HIT  = 2'h0;
    localparam [1:0] KIND_PAGE_MISS = 2'h1;
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_LEAD  = 3'h2;
    localparam [2:0] ST_BURST = 3'h4;

    // ----------------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------------
    // Clocks between data transfers for a burst code; beat 0 is the first transfer after leadoff.
    function [2:0] beat_spacing;
        input [1:0] code;
        input [1:0] beat;
        begin
            if (code == `DTC_BURST_222)
            begin
                beat_spacing = 3'h2;
            end
            else if (code == `DTC_BURST_322)
            begin
                beat_spacing = (beat == 2'h0) ? 3'h3 : 3'h2;
            end
            else if (code == `DTC_BURST_333)
            begin
                beat_spacing = 3'h3;
            end
            else
            begin
                beat_spacing = 3'h4;
            end
        end
    endfunction

    // Page mode parts lack the x222 and x322 rates.
    function [1:0] read_code;
        input [1:0] field;
        input       is_edo;
        begin
            if (is_edo)
            begin
                read_code = field;
            end
            else
            begin
                read_code = field[1] ? `DTC_BURST_333 : `DTC_BURST_444;
            end
        end
    endfunction

    function [3:0] sat_dec;
        input [3:0] val;
        input       dec;
        begin
            sat_dec = (dec && val > 4'h1) ? val - 4'h1 : val;
        end
    endfunction

    // ----------------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------------
    reg  [7:0]  timing_reg;
    reg  [7:0]  row_type_reg;
    reg  [7:0]  ext_ctrl_reg;
    reg  [2:0]  state_reg;
    reg  [3:0]  count_reg;
    reg  [1:0]  beat_reg;
    reg  [1:0]  burst_code_reg;
    reg         fast_burst_reg;

    wire        bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        bus_write = bus_req & wb_we_i & wb_sel_i[0];

    wire        fast_addr_to_row_strobe = timing_reg[`DTC_FAST_ADDR_TO_ROW_STROBE_BIT];
    wire [1:0]  read_burst_rate         = timing_reg[`DTC_RBT_HI:`DTC_RBT_LO];
    wire [1:0]  write_burst_rate        = timing_reg[`DTC_WBT_HI:`DTC_WBT_LO];
    wire        fast_row_to_col_delay   = timing_reg[`DTC_FAST_ROW_TO_COL_DELAY_BIT];
    wire [1:0]  leadoff_select          = timing_reg[`DTC_DLT_HI:`DTC_DLT_LO];
    wire        fast_edo_path_select    = ext_ctrl_reg[`DTC_FAST_EDO_PATH_SELECT_BIT];
    wire        speculative_leadoff     = ext_ctrl_reg[`DTC_SLE_BIT];

    // ----------------------------------------------------------------------
    // Wishbone slave: one wait state, ack for one cycle, unmapped reads zero
    // ----------------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timing_reg   <= `DTC_RST_TIMING;
            row_type_reg <= `DTC_RST_ROW_TYPE;
            ext_ctrl_reg <= `DTC_RST_EXT_CTRL;
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= 32'h0;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_write && wb_adr_i == `DTC_ADDR_TIMING)
            begin
                timing_reg <= wb_dat_i[7:0];
            end
            else if (bus_write && wb_adr_i == `DTC_ADDR_ROW_TYPE)
            begin
                row_type_reg <= {3'h0, wb_dat_i[4:0]};
            end
            else if (bus_write && wb_adr_i == `DTC_ADDR_EXT_CTRL)
            begin
                ext_ctrl_reg <= {2'h0, wb_dat_i[5:4], 4'h0};
            end
            if (bus_req && wb_adr_i == `DTC_ADDR_TIMING)
            begin
                wb_dat_o <= {24'h0, timing_reg};
            end
            else if (bus_req && wb_adr_i == `DTC_ADDR_ROW_TYPE)
            begin
                wb_dat_o <= {24'h0, row_type_reg};
            end
            else if (bus_req && wb_adr_i == `DTC_ADDR_EXT_CTRL)
            begin
                wb_dat_o <= {24'h0, ext_ctrl_reg};
            end
            else if (bus_req && wb_adr_i == `DTC_ADDR_STATUS)
            begin
                wb_dat_o <= {21'h0, dram_busy, leadoff_phase, data_path_select_out,
                             3'h0, burst_code_reg, state_reg};
            end
            else if (bus_req)
            begin
                wb_dat_o <= 32'h0;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Timing selection for a cycle about to start
    // ----------------------------------------------------------------------
    reg         sel_edo;
    reg         sel_fast_path;
    reg  [1:0]  sel_code;
    reg  [3:0]  sel_lead;
    reg  [3:0]  sel_pre;

    always @*
    begin
        sel_edo  = (dram_row < NUM_ROWS) ? row_type_reg[dram_row] : 1'b0;
        sel_code = dram_write ? write_burst_rate
                              : read_code(read_burst_rate, sel_edo);
        sel_fast_path = fast_edo_path_select & sel_edo & ~dram_write;
        sel_pre  = leadoff_select[1] ? `DTC_PRE_LONG : `DTC_PRE_SHORT;
        if (dram_kind == KIND_PAGE_HIT)
        begin
            // Hit leadoff ignores the leadoff field and the miss-only bits.
            sel_lead = dram_write ? `DTC_WR_HIT_LEAD : `DTC_RD_HIT_LEAD;
            sel_lead = sat_dec(sel_lead, sel_fast_path);
        end
        else
        begin
            if (dram_write)
            begin
                sel_lead = leadoff_select[0] ? `DTC_WR_LEAD_FAST : `DTC_WR_LEAD_SLOW;
            end
            else
            begin
                sel_lead = leadoff_select[0] ? `DTC_RD_LEAD_FAST : `DTC_RD_LEAD_SLOW;
            end
            // Each fast bit trims one clock on top of the leadoff field.
            sel_lead = sat_dec(sel_lead, fast_row_to_col_delay);
            sel_lead = sat_dec(sel_lead, speculative_leadoff);
            sel_lead = sat_dec(sel_lead, sel_fast_path);
            // The address setup saving applies to row misses only.
            sel_lead = sat_dec(sel_lead, fast_addr_to_row_strobe && dram_kind != KIND_PAGE_MISS);
            sel_lead = sat_dec(sel_lead, dram_kind == KIND_PAGE_MISS);
        end
    end

    // ----------------------------------------------------------------------
    // Leadoff and burst sequencer
    // ----------------------------------------------------------------------
    // Parameters are captured only when a cycle starts, so a register write
    // landing mid-cycle never disturbs the access in flight.
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg            <= ST_IDLE;
            count_reg            <= 4'h0;
            beat_reg             <= 2'h0;
            burst_code_reg       <= `DTC_BURST_444;
            fast_burst_reg       <= 1'b0;
            dram_busy            <= 1'b0;
            leadoff_phase        <= 1'b0;
            xfer_pulse           <= 1'b0;
            data_path_select_out <= 1'b0;
            ma_to_ras_clks       <= `DTC_MA_RAS_SLOW;
            ras_to_cas_clks      <= `DTC_RAS_CAS_SLOW;
            leadoff_clks         <= `DTC_RD_LEAD_SLOW;
            precharge_clks       <= `DTC_PRE_SHORT;
            burst_spacing_clks   <= 3'h4;
        end
        else
        begin
            xfer_pulse <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (dram_start)
                    begin
                        state_reg            <= ST_LEAD;
                        ma_to_ras_clks       <= fast_addr_to_row_strobe ? `DTC_MA_RAS_FAST
                                                                       : `DTC_MA_RAS_SLOW;
                        ras_to_cas_clks      <= fast_row_to_col_delay ? `DTC_RAS_CAS_FAST
                                                                     : `DTC_RAS_CAS_SLOW;
                        leadoff_clks         <= sel_lead;
                        precharge_clks       <= sel_pre;
                        burst_code_reg       <= sel_code;
                        burst_spacing_clks   <= beat_spacing(sel_code, 2'h0);
                        // Burst keeps the fast path only at x222; x322 falls back to slow.
                        fast_burst_reg       <= sel_fast_path && sel_code == `DTC_BURST_222;
                        data_path_select_out <= sel_fast_path;
                        count_reg            <= sel_lead - 4'h1;
                        beat_reg             <= 2'h0;
                        dram_busy            <= 1'b1;
                        leadoff_phase        <= 1'b1;
                    end
                end
                ST_LEAD:
                begin
                    if (count_reg == 4'h0)
                    begin
                        state_reg            <= ST_BURST;
                        xfer_pulse           <= 1'b1;
                        leadoff_phase        <= 1'b0;
                        data_path_select_out <= fast_burst_reg;
                        count_reg            <= {1'b0, beat_spacing(burst_code_reg, 2'h0)} - 4'h1;
                    end
                    else
                    begin
                        count_reg <= count_reg - 4'h1;
                    end
                end
                ST_BURST:
                begin
                    if (count_reg == 4'h0)
                    begin
                        xfer_pulse <= 1'b1;
                        burst_spacing_clks <= beat_spacing(burst_code_reg, beat_reg + 2'h1);
                        if (beat_reg == `DTC_BURST_BEATS - 2'h1)
                        begin
                            state_reg            <= ST_IDLE;
                            dram_busy            <= 1'b0;
                            data_path_select_out <= 1'b0;
                        end
                        else
                        begin
                            beat_reg  <= beat_reg + 2'h1;
                            count_reg <= {1'b0, beat_spacing(burst_code_reg, beat_reg + 2'h1)} - 4'h1;
                        end
                    end
                    else
                    begin
                        count_reg <= count_reg - 4'h1;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // dtc_dram_timing_config
`default_nettype wire

// file: core/dtc_consts.vh
// Register map, field positions, reset values and timing figures of the DRAM timing selection block.
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define DTC_ADDR_TIMING      8'h58
`define DTC_ADDR_ROW_TYPE    8'h5c
`define DTC_ADDR_EXT_CTRL    8'h60
`define DTC_ADDR_STATUS      8'h64

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DTC_RST_TIMING       8'h00
`define DTC_RST_ROW_TYPE     8'h00
`define DTC_RST_EXT_CTRL     8'h00

// ----------------------------------------------------------------------
// Timing register fields
// ----------------------------------------------------------------------
`define DTC_FAST_ADDR_TO_ROW_STROBE_BIT         7
`define DTC_RBT_HI           6
`define DTC_RBT_LO           5
`define DTC_WBT_HI           4
`define DTC_WBT_LO           3
`define DTC_FAST_ROW_TO_COL_DELAY_BIT         2
`define DTC_DLT_HI           1
`define DTC_DLT_LO           0

// ----------------------------------------------------------------------
// Extended control register fields
// ----------------------------------------------------------------------
`define DTC_FAST_EDO_PATH_SELECT_BIT         5
`define DTC_SLE_BIT          4

// ----------------------------------------------------------------------
// Burst rate codes
// ----------------------------------------------------------------------
`define DTC_BURST_444        2'h0
`define DTC_BURST_333        2'h1
`define DTC_BURST_222        2'h2
`define DTC_BURST_322        2'h3

// ----------------------------------------------------------------------
// Timing figures in host clocks
// ----------------------------------------------------------------------
`define DTC_MA_RAS_FAST      4'h1
`define DTC_MA_RAS_SLOW      4'h2
`define DTC_RAS_CAS_FAST     4'h2
`define DTC_RAS_CAS_SLOW     4'h3
`define DTC_RD_LEAD_SLOW     4'hb
`define DTC_RD_LEAD_FAST     4'ha
`define DTC_WR_LEAD_SLOW     4'h7
`define DTC_WR_LEAD_FAST     4'h6
`define DTC_PRE_SHORT        4'h3
`define DTC_PRE_LONG         4'h4
`define DTC_RD_HIT_LEAD      4'h7
`define DTC_WR_HIT_LEAD      4'h3
`define DTC_PAGE_MISS_SAVE   4'h1
`define DTC_BURST_BEATS      2'h3

`endif

// file: bench/dtc_timing_checker.sv
// Concurrent checks on the register bus and DRAM cycle timing of the timing selection block.
`timescale 1ns/1ns
`default_nettype none
module dtc_timing_checker #(
    parameter int NUM_ROWS = 5
) (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_ack_o,
    input wire logic        dram_start,
    input wire logic [2:0]  dram_row,
    input wire logic        dram_write,
    input wire logic [1:0]  dram_kind,
    input wire logic        dram_busy,
    input wire logic        leadoff_phase,
    input wire logic        xfer_pulse,
    input wire logic        data_path_select_out,
    input wire logic [3:0]  ma_to_ras_clks,
    input wire logic [3:0]  ras_to_cas_clks,
    input wire logic [3:0]  leadoff_clks,
    input wire logic [3:0]  precharge_clks
);
    // ------------------------------------------------------------------
    // Shadow settings and expectations latched when a cycle is taken
    // ------------------------------------------------------------------
    logic [7:0] tim_reg, rt_reg, ext_reg;
    logic [3:0] e_ma_reg, e_rc_reg, e_pre_reg, e_lead_reg, lead_cnt_reg;
    logic [2:0] xfer_cnt_reg;
    logic       e_dps_reg;
    int         base, save;
    wire        wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    wire        take    = dram_start && !dram_busy;
    wire        fast    = ext_reg[5] && (dram_row < NUM_ROWS) && rt_reg[dram_row] && !dram_write;
    always_comb
    begin
        base = (dram_kind == 2'h0) ? (dram_write ? 3 : 7) : (dram_write ? 7 : 11) - int'(tim_reg[0]);
        save = int'(fast) + int'(dram_kind[1] && tim_reg[7]);
        if (dram_kind != 2'h0)
            save = save + int'(tim_reg[2]) + int'(ext_reg[4]) + int'(dram_kind == 2'h1);
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tim_reg      <= 8'h00;
            rt_reg       <= 8'h00;
            ext_reg      <= 8'h00;
            e_ma_reg     <= 4'h2;
            e_rc_reg     <= 4'h3;
            e_pre_reg    <= 4'h3;
            e_lead_reg   <= 4'hb;
            e_dps_reg    <= 1'b0;
            lead_cnt_reg <= 4'h0;
            xfer_cnt_reg <= 3'h0;
        end
        else
        begin
            if (wr_take && wb_adr_i == 8'h58)
                tim_reg <= wb_dat_i[7:0];
            if (wr_take && wb_adr_i == 8'h5c)
                rt_reg <= wb_dat_i[7:0];
            if (wr_take && wb_adr_i == 8'h60)
                ext_reg <= wb_dat_i[7:0];
            if (take)
            begin
                e_ma_reg     <= tim_reg[7] ? 4'h1 : 4'h2;
                e_rc_reg     <= tim_reg[2] ? 4'h2 : 4'h3;
                e_pre_reg    <= tim_reg[1] ? 4'h4 : 4'h3;
                e_lead_reg   <= (base - save > 1) ? 4'(base - save) : 4'h1;
                e_dps_reg    <= fast;
                lead_cnt_reg <= 4'h0;
                xfer_cnt_reg <= 3'h0;
            end
            else
            begin
                if (dram_busy && leadoff_phase)
                    lead_cnt_reg <= lead_cnt_reg + 4'h1;
                if (xfer_pulse)
                    xfer_cnt_reg <= xfer_cnt_reg + 3'h1;
            end
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_begin;
        $rose(dram_busy);
    endsequence
    a_ack_follows_req: assert property (s_req |=> wb_ack_o) else $error("no ack after request");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_addr_row_delay: assert property (s_begin |-> ma_to_ras_clks == e_ma_reg)
        else $error("address setup wrong");
    a_row_col_delay: assert property (s_begin |-> ras_to_cas_clks == e_rc_reg)
        else $error("row to column strobe delay wrong");
    a_precharge_code: assert property (s_begin |-> precharge_clks == e_pre_reg)
        else $error("precharge count wrong");
    a_leadoff_count: assert property (s_begin |-> leadoff_clks == e_lead_reg)
        else $error("leadoff count wrong");
    a_fast_path_select: assert property (s_begin |-> data_path_select_out == e_dps_reg)
        else $error("data path select wrong at leadoff");
    a_first_xfer_time: assert property ($fell(leadoff_phase) |-> xfer_pulse && lead_cnt_reg == leadoff_clks)
        else $error("first transfer not at end of leadoff");
    a_four_transfers: assert property ($fell(dram_busy) |-> xfer_pulse && xfer_cnt_reg == 3'h3)
        else $error("cycle did not end on fourth transfer");
    a_settings_hold: assert property (dram_busy && !$rose(dram_busy) |-> $stable(leadoff_clks))
        else $error("timing changed inside a cycle");
endmodule // dtc_timing_checker

bind dtc_dram_timing_config dtc_timing_checker #(.NUM_ROWS(NUM_ROWS)) u_checker (
    .ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_ack_o, .dram_start,
    .dram_row, .dram_write, .dram_kind, .dram_busy, .leadoff_phase, .xfer_pulse, .data_path_select_out,
    .ma_to_ras_clks, .ras_to_cas_clks, .leadoff_clks, .precharge_clks);
`default_nettype wire

// file: bench/dtc_dram_rows.sv
// Behavioural stand-in for the DRAM rows: issues cycles and times each transfer.
`timescale 1ns/1ns
`default_nettype none
module dtc_dram_rows (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       go,
    input  wire logic [2:0] req_row,
    input  wire logic       req_write,
    input  wire logic [1:0] req_kind,
    input  wire logic       xfer_pulse,
    input  wire logic       data_path_select_out,
    output var  logic       dram_start,
    output var  logic [2:0] dram_row,
    output var  logic       dram_write,
    output var  logic [1:0] dram_kind,
    output var  logic [7:0] xfer_time [4],
    output var  logic [2:0] xfer_count,
    output var  logic       beat_path
);
    logic [7:0] age_reg;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dram_start <= 1'b0;
            dram_row   <= 3'h0;
            dram_write <= 1'b0;
            dram_kind  <= 2'h0;
            xfer_time  <= '{default: 8'h00};
            xfer_count <= 3'h0;
            beat_path  <= 1'b0;
            age_reg    <= 8'h00;
        end
        else
        begin
            dram_start <= go;
            age_reg    <= dram_start ? 8'h00 : age_reg + 8'h01;
            if (go)
            begin
                dram_row   <= req_row;
                dram_write <= req_write;
                dram_kind  <= req_kind;
                xfer_count <= 3'h0;
            end
            else if (dram_start)
            begin
                // Scramble stale request lines to expose late sampling.
                dram_row   <= ~dram_row;
                dram_write <= ~dram_write;
                dram_kind  <= ~dram_kind;
            end
            if (xfer_pulse && !go)
            begin
                xfer_time[xfer_count[1:0]] <= age_reg;
                xfer_count <= xfer_count + 3'h1;
                if (xfer_count == 3'h1)
                    beat_path <= data_path_select_out;
            end
        end
    end
endmodule // dtc_dram_rows
`default_nettype wire

// file: bench/test_dram_timing_config.sv
// Self-checking bench for the DRAM timing selection block.
`timescale 1ns/1ns
`default_nettype none
module test_dram_timing_config;
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, rq_w = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [3:0]  sel = 4'h0, ma, rc, lead, pre;
    logic [2:0]  rq_row = 3'h0, drow, nx, spc;
    logic [1:0]  rq_k = 2'h0, dk;
    logic        ack, start, dw, busy, lph, xfer, dps, bpath;
    logic [7:0]  xt [4];
    int          errors = 0, total_checks = 0;
    always #4 ref_clk = ~ref_clk;
    dtc_dram_timing_config dut (.ref_clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .dram_start(start),
        .dram_row(drow), .dram_write(dw), .dram_kind(dk), .dram_busy(busy), .leadoff_phase(lph),
        .xfer_pulse(xfer), .data_path_select_out(dps), .ma_to_ras_clks(ma), .ras_to_cas_clks(rc),
        .leadoff_clks(lead), .precharge_clks(pre), .burst_spacing_clks(spc));
    dtc_dram_rows rows (.ref_clk, .rst_n, .go, .req_row(rq_row), .req_write(rq_w),
        .req_kind(rq_k), .xfer_pulse(xfer), .data_path_select_out(dps), .dram_start(start), .dram_row(drow),
        .dram_write(dw), .dram_kind(dk), .xfer_time(xt), .xfer_count(nx), .beat_path(bpath));
    // ------------------------------------------------------------------
    // Bus cycles, comparison and closing report
    // ------------------------------------------------------------------
    task automatic summarize;
        if (errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, d, input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h0, d};
        sel  <= s;
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
        if (n >= 50)
        begin
            errors++;
            summarize();
        end
    endtask
    // One DRAM cycle; mid rewrites the timing register during the leadoff.
    task automatic run(input logic [7:0] tim, ext, rt, input logic [2:0] row, input logic w, input logic [1:0] k,
                       input logic [7:0] exp_lead, input logic [11:0] sp, input logic db, mid);
        logic [31:0] q;
        int          n;
        wb(1'b1, 8'h58, tim, 4'h1, q);
        wb(1'b1, 8'h60, ext, 4'h1, q);
        wb(1'b1, 8'h5c, rt, 4'h1, q);
        go     <= 1'b1;
        rq_row <= row;
        rq_w   <= w;
        rq_k   <= k;
        @(posedge ref_clk);
        go <= 1'b0;
        if (mid)
        begin
            repeat (2) @(posedge ref_clk);
            wb(1'b1, 8'h58, 8'h50, 4'h1, q);
        end
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (nx !== 3'h4 && n < 200);
        if (n >= 200)
        begin
            errors++;
            summarize();
        end
        check(xt[0], exp_lead, "leadoff");
        check({4'(xt[1] - xt[0]), 4'(xt[2] - xt[1]), 4'(xt[3] - xt[2])}, sp, "burst spacing");
        check(bpath, db, "burst path select");
        check(spc, sp[3:0], "next beat spacing");
    endtask
    initial
    begin
        logic [31:0] q;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        wb(1'b0, 8'h58, 8'h00, 4'h1, q);
        check(q, 32'h0, "timing after reset");
        wb(1'b0, 8'h64, 8'h00, 4'h1, q);
        check(q, 32'h1, "idle status");
        wb(1'b1, 8'h58, 8'ha5, 4'h0, q);
        wb(1'b0, 8'h58, 8'h00, 4'h1, q);
        check(q, 32'h0, "timing after unselected write");
        wb(1'b1, 8'h58, 8'ha5, 4'h1, q);
        wb(1'b0, 8'h58, 8'h00, 4'h1, q);
        check(q, 32'ha5, "timing readback");
        wb(1'b1, 8'h70, 8'hff, 4'h1, q);
        wb(1'b0, 8'h70, 8'h00, 4'h1, q);
        check(q, 32'h0, "unmapped read");
        run(8'h00, 8'h00, 8'h00, 3'h0, 1'b0, 2'h2, 8'd11, 12'h444, 1'b0, 1'b0);
        run(8'h01, 8'h00, 8'h00, 3'h0, 1'b1, 2'h2, 8'd6, 12'h444, 1'b0, 1'b0);
        run(8'h86, 8'h10, 8'h00, 3'h0, 1'b0, 2'h3, 8'd8, 12'h444, 1'b0, 1'b0);
        run(8'h40, 8'h20, 8'h01, 3'h0, 1'b0, 2'h1, 8'd9, 12'h222, 1'b1, 1'b0);
        run(8'h40, 8'h00, 8'h01, 3'h0, 1'b0, 2'h1, 8'd10, 12'h222, 1'b0, 1'b0);
        run(8'h60, 8'h20, 8'h01, 3'h0, 1'b0, 2'h0, 8'd6, 12'h322, 1'b0, 1'b0);
        run(8'h60, 8'h20, 8'h01, 3'h1, 1'b0, 2'h0, 8'd7, 12'h333, 1'b0, 1'b0);
        run(8'h20, 8'h00, 8'h02, 3'h1, 1'b0, 2'h0, 8'd7, 12'h333, 1'b0, 1'b0);
        run(8'h10, 8'h20, 8'h00, 3'h0, 1'b1, 2'h0, 8'd3, 12'h222, 1'b0, 1'b0);
        run(8'h0b, 8'h00, 8'h00, 3'h0, 1'b1, 2'h2, 8'd6, 12'h333, 1'b0, 1'b0);
        run(8'h03, 8'h00, 8'h00, 3'h0, 1'b0, 2'h0, 8'd7, 12'h444, 1'b0, 1'b0);
        run(8'h00, 8'h00, 8'h00, 3'h0, 1'b0, 2'h0, 8'd7, 12'h444, 1'b0, 1'b1);
        summarize();
    end
endmodule // test_dram_timing_config
`default_nettype wire
